// ==== sbt_pkg.sv ====
// Constants, types and register map of the sixteen-bit timer block
package sbt_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL_A = 8'h80;
  localparam logic [7:0] ADDR_CTRL_B = 8'h81;
  localparam logic [7:0] ADDR_FORCE = 8'h82;
  localparam logic [7:0] ADDR_FLAGS = 8'h83;
  localparam logic [7:0] ADDR_CNT_L = 8'h84;
  localparam logic [7:0] ADDR_CNT_H = 8'h85;
  localparam logic [7:0] ADDR_CAP_L = 8'h86;
  localparam logic [7:0] ADDR_CAP_H = 8'h87;
  localparam logic [7:0] ADDR_CMPA_L = 8'h88;
  localparam logic [7:0] ADDR_CMPA_H = 8'h89;
  localparam logic [7:0] ADDR_CMPB_L = 8'h8A;
  localparam logic [7:0] ADDR_CMPB_H = 8'h8B;

  // Field positions
  localparam int CA_COMA_LSB = 6;
  localparam int CA_COMB_LSB = 4;
  localparam int CB_NOISE_BIT = 7;
  localparam int CB_EDGE_BIT = 6;
  localparam int CF_FORCE_A_BIT = 7;
  localparam int CF_FORCE_B_BIT = 6;
  localparam int FL_CAP_BIT = 5;
  localparam int FL_CMPB_BIT = 2;
  localparam int FL_CMPA_BIT = 1;
  localparam int FL_OVF_BIT = 0;

  // Writable masks and reset values
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK = 8'hDF;
  localparam logic [7:0] FLAGS_MASK = 8'h27;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Fixed tops
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Noise filter length in samples
  localparam int FILTER_LEN = 4;

  // Count sequence kinds
  typedef enum logic [2:0] {
    K_NORMAL, K_CTC, K_FAST, K_PC, K_PFC, K_RSVD
  } sbt_kind_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sbt_bus_req_t;

  // Whole state of the timer
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] flags;
    logic [7:0] temp;
    logic [7:0] rdata;
    logic [15:0] cnt;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [15:0] cmpa_buf;
    logic [15:0] cmpb_buf;
    logic [15:0] cap;
    logic [9:0] pre;
    logic [FILTER_LEN-1:0] filt_sh;
    logic filt;
    logic cap_prev;
    logic ext_prev;
    logic down;
    logic block;
    logic oca;
    logic ocb;
  } sbt_state_t;

endpackage : sbt_pkg

// ==== sbt_timer16.sv ====
// Sixteen-bit timer/counter: mode decode, capture, clock select, forcing
//
// How it works
// - Waveform mode is control A bits 1:0 joined with control B bits 4:3.
// - Mode 0 counts up to 0xFFFF, immediate compare load, overflow at max.
// - Modes 4 and 12 clear at compare A or capture top; mode 13 reserved.
// - Modes 1-3 phase correct, tops 0x00FF/0x01FF/0x03FF, load top, flag bottom.
// - Modes 5-7,14,15 fast PWM; load at bottom, overflow at top.
// - Modes 8,9 load and flag at bottom; modes 10,11 load at top.
// - Noise filter passes capture pin after four equal samples.
// - Edge select zero picks falling capture edge, one picks rising.
// - Capture edge copies counter to capture value and sets capture flag.
// - Capture input is disconnected while capture value is top.
// - Clock select 0 stops, 1 undivided, 2-5 divide by 8/64/256/1024.
// - Clock select 6 and 7 count falling or rising external pin edges.
// - External pin edges count even while the pin is an output.
// - Force bit in non-PWM mode acts as compare match on its output.
// - Forced match sets no flag and never clears the counter.
// - Force bits are strobes and always read as zero.
// - Sixteen-bit writes move as one value through a shared high byte; count and capture reads do too.
// - Counter write suppresses compare match on the next timer tick.
// - Prescaler free-runs regardless of clock select.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

module sbt_timer16 import sbt_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port
  input wire sbt_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // Board pins
  input wire logic capture_pin,
  input wire logic external_count_pin,
  output logic compare_output_a,
  output logic compare_output_b,
  // Event flags as levels
  output logic [7:0] event_flags
);

  sbt_state_t s_ff;
  sbt_state_t nxt_s;

  logic [3:0] waveform_mode;
  logic [2:0] clock_select;
  sbt_kind_t kind;
  logic [15:0] top;
  logic icr_top;
  logic pwm;
  logic tick;
  logic cap_src;
  logic cap_ev;
  logic at_top;
  logic at_bot;
  logic ovf_ev;
  logic load_ev;
  logic match_a;
  logic match_b;
  logic force_a;
  logic force_b;
  logic wr_cnt;
  logic [7:0] set_flags;

  assign waveform_mode = {s_ff.ctrl_b[4:3], s_ff.ctrl_a[1:0]};
  assign clock_select = s_ff.ctrl_b[2:0];

  // Mode decode: sequence kind, top source
  always_comb begin
    kind = K_NORMAL;
    top = COUNT_MAX;
    case (waveform_mode)
      4'h0: begin
        kind = K_NORMAL;
        top = COUNT_MAX;
      end
      4'h1: begin
        kind = K_PC;
        top = TOP_8BIT;
      end
      4'h2: begin
        kind = K_PC;
        top = TOP_9BIT;
      end
      4'h3: begin
        kind = K_PC;
        top = TOP_10BIT;
      end
      4'h4: begin
        kind = K_CTC;
        top = s_ff.cmpa;
      end
      4'h5: begin
        kind = K_FAST;
        top = TOP_8BIT;
      end
      4'h6: begin
        kind = K_FAST;
        top = TOP_9BIT;
      end
      4'h7: begin
        kind = K_FAST;
        top = TOP_10BIT;
      end
      4'h8: begin
        kind = K_PFC;
        top = s_ff.cap;
      end
      4'h9: begin
        kind = K_PFC;
        top = s_ff.cmpa;
      end
      4'hA: begin
        kind = K_PC;
        top = s_ff.cap;
      end
      4'hB: begin
        kind = K_PC;
        top = s_ff.cmpa;
      end
      4'hC: begin
        kind = K_CTC;
        top = s_ff.cap;
      end
      4'hE: begin
        kind = K_FAST;
        top = s_ff.cap;
      end
      4'hF: begin
        kind = K_FAST;
        top = s_ff.cmpa;
      end
      // reserved mode 13 lands here and holds the counter still
      default: begin
        kind = K_RSVD;
        top = COUNT_MAX;
      end
    endcase
  end

  assign icr_top = (waveform_mode == 4'h8) || (waveform_mode == 4'hA) ||
                   (waveform_mode == 4'hC) || (waveform_mode == 4'hE);
  assign pwm = (kind == K_FAST) || (kind == K_PC) || (kind == K_PFC);

  // Count enable: taps of the shared free-running prescaler or pin edges
  always_comb begin
    case (clock_select)
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = &s_ff.pre[2:0];
      CS_DIV64: tick = &s_ff.pre[5:0];
      CS_DIV256: tick = &s_ff.pre[7:0];
      CS_DIV1024: tick = &s_ff.pre;
      // pin is watched whatever its port direction
      CS_EXT_FALL: tick = s_ff.ext_prev & ~external_count_pin;
      CS_EXT_RISE: tick = ~s_ff.ext_prev & external_count_pin;
      default: tick = 1'b0;
    endcase
  end

  assign cap_src = s_ff.ctrl_b[CB_NOISE_BIT] ? s_ff.filt : capture_pin;
  // edge choice, dead while capture value is top
  assign cap_ev = !icr_top && (s_ff.ctrl_b[CB_EDGE_BIT] ?
                  (cap_src & ~s_ff.cap_prev) : (~cap_src & s_ff.cap_prev));

  assign at_top = (s_ff.cnt == top);
  assign at_bot = (s_ff.cnt == WORD_RST);
  // matches blocked on the tick after a counter write
  assign match_a = tick && !s_ff.block && (s_ff.cnt == s_ff.cmpa);
  assign match_b = tick && !s_ff.block && (s_ff.cnt == s_ff.cmpb);
  assign wr_cnt = bus_req.wr && (bus_req.addr == ADDR_CNT_L);
  // forcing works only outside PWM modes
  assign force_a = bus_req.wr && (bus_req.addr == ADDR_FORCE) && !pwm &&
                   bus_req.wdata[CF_FORCE_A_BIT];
  assign force_b = bus_req.wr && (bus_req.addr == ADDR_FORCE) && !pwm &&
                   bus_req.wdata[CF_FORCE_B_BIT];

  // Overflow and buffered-load moments per sequence kind
  always_comb begin
    ovf_ev = 1'b0;
    load_ev = 1'b0;
    case (kind)
      // flag at max, loads are immediate
      K_NORMAL, K_CTC: ovf_ev = tick && (s_ff.cnt == COUNT_MAX);
      // flag at top, load as the count returns to bottom
      K_FAST: begin
        ovf_ev = tick && at_top;
        load_ev = tick && at_top;
      end
      // flag at bottom, load at top
      K_PC: begin
        ovf_ev = tick && s_ff.down && at_bot;
        load_ev = tick && !s_ff.down && at_top;
      end
      K_PFC: begin
        ovf_ev = tick && s_ff.down && at_bot;
        load_ev = tick && s_ff.down && at_bot;
      end
      default: ovf_ev = 1'b0;
    endcase
  end

  // hardware events only; forcing never reaches the flags
  always_comb begin
    set_flags = 8'h00;
    set_flags[FL_OVF_BIT] = ovf_ev;
    set_flags[FL_CMPA_BIT] = match_a;
    set_flags[FL_CMPB_BIT] = match_b;
    // Capture flag also marks top when capture value is top
    set_flags[FL_CAP_BIT] = cap_ev || (icr_top && tick && at_top);
  end

  // Output action for a compare match in non-PWM modes
  function automatic logic oc_act(input logic [1:0] com, input logic cur);
    case (com)
      2'h1: oc_act = ~cur;
      2'h2: oc_act = 1'b0;
      2'h3: oc_act = 1'b1;
      default: oc_act = cur;
    endcase
  endfunction : oc_act

  // Next state
  always_comb begin
    nxt_s = s_ff;
    // prescaler never stops or resets with clock select
    nxt_s.pre = s_ff.pre + 10'h001;
    nxt_s.ext_prev = external_count_pin;
    nxt_s.rdata = 8'h00;

    // filter output moves only on four equal samples
    nxt_s.filt_sh = {s_ff.filt_sh[FILTER_LEN-2:0], capture_pin};
    if (&nxt_s.filt_sh || ~|nxt_s.filt_sh) begin
      nxt_s.filt = capture_pin;
    end
    nxt_s.cap_prev = cap_src;

    // Count sequence
    if (tick) begin
      nxt_s.block = 1'b0;
      case (kind)
        // clear at top, wraps at max
        K_NORMAL, K_CTC, K_FAST: begin
          nxt_s.cnt = at_top ? WORD_RST : s_ff.cnt + 16'h0001;
        end
        // dual-slope with turn at top and bottom
        K_PC, K_PFC: begin
          if (s_ff.down) begin
            nxt_s.down = !at_bot;
            nxt_s.cnt = at_bot ? s_ff.cnt + 16'h0001 : s_ff.cnt - 16'h0001;
          end else begin
            nxt_s.down = at_top;
            nxt_s.cnt = at_top ? s_ff.cnt - 16'h0001 : s_ff.cnt + 16'h0001;
          end
        end
        default: nxt_s.cnt = s_ff.cnt;
      endcase
    end

    // Double-buffered compare loads, else immediate
    if (!pwm || load_ev) begin
      nxt_s.cmpa = s_ff.cmpa_buf;
      nxt_s.cmpb = s_ff.cmpb_buf;
    end

    if (cap_ev) begin
      nxt_s.cap = s_ff.cnt;
    end

    // compare outputs driven only outside PWM modes
    if (!pwm && (match_a || force_a)) begin
      nxt_s.oca = oc_act(s_ff.ctrl_a[CA_COMA_LSB +: 2], s_ff.oca);
    end
    if (!pwm && (match_b || force_b)) begin
      nxt_s.ocb = oc_act(s_ff.ctrl_a[CA_COMB_LSB +: 2], s_ff.ocb);
    end

    // Flags: write one clears, a same-cycle event wins
    if (bus_req.wr && (bus_req.addr == ADDR_FLAGS)) begin
      nxt_s.flags = s_ff.flags & ~bus_req.wdata;
    end
    nxt_s.flags = (nxt_s.flags | set_flags) & FLAGS_MASK;

    // Register writes; software wins over the counter sequence
    if (bus_req.wr) begin
      case (bus_req.addr)
        ADDR_CTRL_A: nxt_s.ctrl_a = bus_req.wdata & CTRL_A_MASK;
        ADDR_CTRL_B: nxt_s.ctrl_b = bus_req.wdata & CTRL_B_MASK;
        // high bytes park in the shared latch
        ADDR_CNT_H, ADDR_CAP_H, ADDR_CMPA_H, ADDR_CMPB_H: begin
          nxt_s.temp = bus_req.wdata;
        end
        // counter write arms the match block
        ADDR_CNT_L: begin
          nxt_s.cnt = {s_ff.temp, bus_req.wdata};
          nxt_s.block = 1'b1;
        end
        ADDR_CAP_L: nxt_s.cap = {s_ff.temp, bus_req.wdata};
        ADDR_CMPA_L: nxt_s.cmpa_buf = {s_ff.temp, bus_req.wdata};
        ADDR_CMPB_L: nxt_s.cmpb_buf = {s_ff.temp, bus_req.wdata};
        default: nxt_s.temp = s_ff.temp;
      endcase
    end

    // Reads: count and capture low bytes snapshot their high half into the latch
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CTRL_A: nxt_s.rdata = s_ff.ctrl_a;
        ADDR_CTRL_B: nxt_s.rdata = s_ff.ctrl_b;
        ADDR_FORCE: nxt_s.rdata = 8'h00;
        ADDR_FLAGS: nxt_s.rdata = s_ff.flags;
        ADDR_CNT_L: begin
          nxt_s.rdata = s_ff.cnt[7:0];
          nxt_s.temp = s_ff.cnt[15:8];
        end
        ADDR_CAP_L: begin
          nxt_s.rdata = s_ff.cap[7:0];
          nxt_s.temp = s_ff.cap[15:8];
        end
        ADDR_CNT_H, ADDR_CAP_H: nxt_s.rdata = s_ff.temp;
        // Compare registers read their buffers directly
        ADDR_CMPA_L: nxt_s.rdata = s_ff.cmpa_buf[7:0];
        ADDR_CMPA_H: nxt_s.rdata = s_ff.cmpa_buf[15:8];
        ADDR_CMPB_L: nxt_s.rdata = s_ff.cmpb_buf[7:0];
        ADDR_CMPB_H: nxt_s.rdata = s_ff.cmpb_buf[15:8];
        default: nxt_s.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state
  assign rd_data = s_ff.rdata;
  assign compare_output_a = s_ff.oca;
  assign compare_output_b = s_ff.ocb;
  assign event_flags = s_ff.flags;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_rsvd_bit_zero: assert property (
    bus_req.rd && bus_req.addr == ADDR_CTRL_B |=> rd_data[5] == 1'b0)
    else $error("reserved control bit read as one");
  chk_force_reads_zero: assert property (
    bus_req.rd && bus_req.addr == ADDR_FORCE |=> rd_data == 8'h00)
    else $error("force register read nonzero");
  chk_normal_wrap: assert property (
    tick && waveform_mode == 4'h0 && s_ff.cnt == COUNT_MAX && !wr_cnt
    |=> s_ff.cnt == WORD_RST && s_ff.flags[FL_OVF_BIT])
    else $error("normal mode wrap or overflow wrong");
  chk_pc_turn_top: assert property (
    tick && waveform_mode == 4'h1 && !s_ff.down && s_ff.cnt == TOP_8BIT && !wr_cnt
    |=> s_ff.down && s_ff.cnt == 16'h00FE)
    else $error("phase correct turn at top wrong");
  chk_filter_delay: assert property (
    $changed(s_ff.filt) |-> s_ff.filt_sh == {FILTER_LEN{s_ff.filt}})
    else $error("filter changed without four equal samples");
  chk_capture_copy: assert property (
    cap_ev && !(bus_req.wr && bus_req.addr == ADDR_CAP_L)
    |=> s_ff.cap == $past(s_ff.cnt) && s_ff.flags[FL_CAP_BIT])
    else $error("capture did not copy count");
  chk_capture_off: assert property (
    icr_top && !(bus_req.wr && bus_req.addr == ADDR_CAP_L) |=> $stable(s_ff.cap))
    else $error("capture active while capture value is top");
  chk_write_blocks: assert property (wr_cnt |=> !match_a && !match_b)
    else $error("match after counter write");
  chk_force_no_flag: assert property (
    force_a && !match_a |=> s_ff.flags[FL_CMPA_BIT] == $past(s_ff.flags[FL_CMPA_BIT]))
    else $error("forced match set a flag");
  chk_count_stop: assert property (
    clock_select == CS_STOP && !wr_cnt |=> $stable(s_ff.cnt))
    else $error("stopped counter moved");

endmodule : sbt_timer16

// ==== sbt_timer16_tb_top.sv ====
// Self-checking testbench for the sixteen-bit timer block
`timescale 1ns/1ps

module sbt_timer16_tb_top import sbt_pkg::*; ;
  // Clock, reset and design pins
  logic mclk;
  logic arst_n;
  sbt_bus_req_t bus_req;
  logic [7:0] rd_data;
  logic capture_pin;
  logic external_count_pin;
  logic compare_output_a;
  logic compare_output_b;
  logic [7:0] event_flags;
  int error_cnt;
  int comparisons;

  // Device under test
  sbt_timer16 i_dut (
    .mclk(mclk),
    .arst_n(arst_n),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .capture_pin(capture_pin),
    .external_count_pin(external_count_pin),
    .compare_output_a(compare_output_a),
    .compare_output_b(compare_output_b),
    .event_flags(event_flags)
  );

  // Free-running 50 MHz clock
  always #10 mclk = ~mclk;

  // Compare and count one result
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // Write strobe one cycle; released at the taking edge
  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask : bw

  // Read data stands only in the cycle after the strobe
  task automatic br(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask : br

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    br(a, d);
    check({8'h00, d}, {8'h00, exp}, msg);
  endtask : rchk

  // High byte goes first; the low write commits the pair
  task automatic w16(input logic [7:0] alo, input logic [15:0] v);
    bw(alo + 8'h01, v[15:8]);
    bw(alo, v[7:0]);
  endtask : w16

  // Low byte first so the high half is latched with it
  task automatic r16(input logic [7:0] alo, output logic [15:0] v);
    br(alo, v[7:0]);
    br(alo + 8'h01, v[15:8]);
  endtask : r16

  // mode split over both control registers
  task automatic cfg(input logic [3:0] m, input logic [7:0] com, input logic [1:0] capc,
                     input logic [2:0] cs);
    bw(ADDR_CTRL_A, com | {6'h00, m[1:0]});
    bw(ADDR_CTRL_B, {capc, 1'b0, m[3:2], cs});
  endtask : cfg

  task automatic clr;
    bw(ADDR_FLAGS, FLAGS_MASK);
  endtask : clr

  // Look just after the edge so the flag launched there has settled
  task automatic flag_is(input int b, input logic exp, input string msg);
    #1;
    check({15'h0000, event_flags[b]}, {15'h0000, exp}, msg);
  endtask : flag_is

  // Bounded wait for a flag; a miss ends the run
  task automatic wait_bit(input int b, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge mclk);
      #1;
      if (event_flags[b] === 1'b1) break;
    end
    comparisons++;
    if (i == n) begin
      error_cnt++;
      $display("[ERR] %0t flag %0d never rose", $time, b);
      stop_test();
    end
  endtask : wait_bit

  // Reset values, masked bits and an unmapped place
  task automatic t_regs;
    rchk(ADDR_CTRL_A, CTRL_RST, "ctrl a reset");
    rchk(ADDR_CTRL_B, CTRL_RST, "ctrl b reset");
    // software always writes the reserved bit as zero
    bw(ADDR_CTRL_B, 8'hD8);
    rchk(ADDR_CTRL_B, 8'hD8, "reserved bit");
    bw(ADDR_CTRL_A, 8'hFF);
    rchk(ADDR_CTRL_A, CTRL_A_MASK, "ctrl a mask");
    cfg(4'h0, 8'h00, 2'b00, CS_STOP);
    bw(ADDR_FORCE, 8'hC0);
    rchk(ADDR_FORCE, 8'h00, "force readback");
    rchk(8'h90, 8'h00, "unmapped read");
    $display("done regs");
  endtask : t_regs

  // Word access and a stopped counter
  task automatic t_word;
    logic [15:0] v;
    w16(ADDR_CNT_L, 16'h1234);
    r16(ADDR_CNT_L, v);
    check(v, 16'h1234, "count word");
    repeat (20) @(posedge mclk);
    r16(ADDR_CNT_L, v);
    check(v, 16'h1234, "stopped count");
    $display("done word");
  endtask : t_word

  // Every prescaler tap runs ten of its periods; first tick may come early or late
  task automatic t_presc;
    int div [5] = '{1, 8, 64, 256, 1024};
    logic [15:0] v;
    for (int i = 0; i < 5; i++) begin
      w16(ADDR_CNT_L, WORD_RST);
      bw(ADDR_CTRL_B, {5'h00, 3'(i + 1)});
      repeat (10 * div[i] - 2) @(posedge mclk);
      bw(ADDR_CTRL_B, {5'h00, CS_STOP});
      r16(ADDR_CNT_L, v);
      check({15'h0000, v >= 16'h0009 && v <= 16'h000B}, 16'h0001, "tap count");
    end
    $display("done prescaler");
  endtask : t_presc

  // pin driven by the bench stands in for software toggling
  task automatic t_ext;
    logic [15:0] v;
    for (int e = 0; e < 2; e++) begin
      w16(ADDR_CNT_L, WORD_RST);
      bw(ADDR_CTRL_B, (e == 1) ? {5'h00, CS_EXT_RISE} : {5'h00, CS_EXT_FALL});
      repeat (5) begin
        external_count_pin <= 1'b1;
        repeat (3) @(posedge mclk);
        external_count_pin <= 1'b0;
        repeat (3) @(posedge mclk);
      end
      bw(ADDR_CTRL_B, {5'h00, CS_STOP});
      r16(ADDR_CNT_L, v);
      check(v, 16'h0005, "external edges");
    end
    $display("done external");
  endtask : t_ext

  // Edge choice, capture copy and filter length
  task automatic t_cap;
    logic [15:0] v;
    bw(ADDR_CTRL_B, 8'h40);
    w16(ADDR_CNT_L, 16'hA5C3);
    clr();
    flag_is(FL_CAP_BIT, 1'b0, "flag cleared");
    capture_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    flag_is(FL_CAP_BIT, 1'b1, "rising capture");
    r16(ADDR_CAP_L, v);
    check(v, 16'hA5C3, "capture value");
    clr();
    capture_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    flag_is(FL_CAP_BIT, 1'b0, "falling ignored");
    bw(ADDR_CTRL_B, 8'h00);
    capture_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    flag_is(FL_CAP_BIT, 1'b0, "rising ignored");
    capture_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    flag_is(FL_CAP_BIT, 1'b1, "falling capture");
    bw(ADDR_CTRL_B, 8'hC0);
    clr();
    // three equal samples must not pass the filter
    capture_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    capture_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    flag_is(FL_CAP_BIT, 1'b0, "short pulse");
    // Raw capture lands on the first edge; filtered exactly four later
    capture_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    flag_is(FL_CAP_BIT, 1'b0, "filter delay");
    wait_bit(FL_CAP_BIT, 1);
    capture_pin <= 1'b0;
    // capture is cut off in capture-top modes
    for (int m = 8; m < 16; m += 2) begin
      cfg(4'(m), 8'h00, 2'b01, CS_STOP);
      clr();
      capture_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      flag_is(FL_CAP_BIT, 1'b0, "capture disabled");
      capture_pin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    $display("done capture");
  endtask : t_cap

  // Forced matches follow the output mode and leave flags and count alone
  task automatic t_force;
    logic [15:0] v;
    cfg(4'h0, 8'h50, 2'b00, CS_STOP);
    w16(ADDR_CNT_L, 16'h0777);
    clr();
    bw(ADDR_FORCE, 8'hC0);
    repeat (2) @(posedge mclk);
    check({14'h0000, compare_output_a, compare_output_b}, 16'h0003, "toggle");
    check({8'h00, event_flags}, 16'h0000, "no flags");
    cfg(4'h4, 8'hA0, 2'b00, CS_STOP);
    bw(ADDR_FORCE, 8'hC0);
    repeat (2) @(posedge mclk);
    check({14'h0000, compare_output_a, compare_output_b}, 16'h0000, "clear");
    cfg(4'h4, 8'hF0, 2'b00, CS_STOP);
    bw(ADDR_FORCE, 8'h80);
    repeat (2) @(posedge mclk);
    check({14'h0000, compare_output_a, compare_output_b}, 16'h0002, "set a only");
    r16(ADDR_CNT_L, v);
    check(v, 16'h0777, "no ctc clear");
    check({8'h00, event_flags}, 16'h0000, "no flags ctc");
    $display("done force");
  endtask : t_force

  // count range and overflow flag checked while all sixteen modes run
  task automatic t_modes;
    // Every mode in order; compare A top is 5, capture top is 7, sixteen ticks each
    logic [15:0] st [16] = '{16'hFFFD, 16'h00FD, 16'h01FD, 16'h03FD, 16'h0000, 16'h00FD,
                             16'h01FD, 16'h03FD, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                             16'h0000, 16'h0055, 16'h0000, 16'h0000};
    logic [15:0] lo [16] = '{16'h0000, 16'h00E0, 16'h01E0, 16'h03E0, 16'h0000, 16'h0000,
                             16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                             16'h0000, 16'h0055, 16'h0000, 16'h0000};
    logic [15:0] hi [16] = '{16'h0020, 16'h00FF, 16'h01FF, 16'h03FF, 16'h0005, 16'h0020,
                             16'h0020, 16'h0020, 16'h0007, 16'h0005, 16'h0007, 16'h0005,
                             16'h0007, 16'h0055, 16'h0007, 16'h0005};
    logic [15:0] ov = 16'hCFE1;
    logic [3:0] m;
    logic [15:0] v;
    cfg(4'h0, 8'h00, 2'b00, CS_STOP);
    w16(ADDR_CMPA_L, 16'h0005);
    w16(ADDR_CAP_L, 16'h0007);
    for (int i = 0; i < 16; i++) begin
      m = 4'(i);
      cfg(m, 8'h00, 2'b00, CS_STOP);
      w16(ADDR_CNT_L, st[i]);
      clr();
      bw(ADDR_CTRL_B, {3'b000, m[3:2], CS_DIV1});
      repeat (14) @(posedge mclk);
      bw(ADDR_CTRL_B, {3'b000, m[3:2], CS_STOP});
      r16(ADDR_CNT_L, v);
      check({15'h0000, v >= lo[i] && v <= hi[i]}, 16'h0001, "mode range");
      flag_is(FL_OVF_BIT, ov[i], "overflow point");
    end
    $display("done modes");
  endtask : t_modes

  // Writing the count hides the match on the following tick only
  task automatic t_block;
    cfg(4'h0, 8'h00, 2'b00, CS_STOP);
    w16(ADDR_CMPA_L, 16'h0010);
    w16(ADDR_CMPB_L, 16'h0010);
    w16(ADDR_CNT_L, 16'h0100);
    bw(ADDR_CTRL_B, {5'h00, CS_DIV1});
    clr();
    w16(ADDR_CNT_L, 16'h0010);
    repeat (4) @(posedge mclk);
    flag_is(FL_CMPA_BIT, 1'b0, "match blocked");
    flag_is(FL_CMPB_BIT, 1'b0, "match b blocked");
    w16(ADDR_CNT_L, 16'h000E);
    wait_bit(FL_CMPA_BIT, 6);
    flag_is(FL_CMPB_BIT, 1'b1, "match b after block");
    bw(ADDR_CTRL_B, {5'h00, CS_STOP});
    $display("done block");
  endtask : t_block

  // Main sequence
  initial begin
    mclk = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    bus_req = '0;
    capture_pin = 1'b0;
    external_count_pin = 1'b0;
    arst_n = 1'b0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_word();
    t_presc();
    t_ext();
    t_cap();
    t_force();
    t_modes();
    t_block();
    stop_test();
  end
endmodule : sbt_timer16_tb_top
